// file: rtl/seqstk_pkg.sv
// constants shared by the sequencer stack entry bank
// assumes one clock (mclk, 20 MHz) and a synchronous active-high reset
// Contract
// - Bit 15 of an entry is the access direction: 0 selects a read, 1 a write.
// - Bits 14 to 9 hold the entry's own 6-bit address, which the host writes there to select it; the bank only stores this field and selects entries by haddr[7:2].
// - With the return flag of the active entry at 0 the sequencer steps to the next entry when a conversion ends.
// - With the return flag of the active entry at 1 the sequencer goes back to the first entry when a conversion ends.
// - Bits 7 to 4 of the active entry pick the converter B channel.
// - Bits 3 to 0 of the active entry pick the converter A channel.
// - Entry four sits at address 0x24 and resets to 0x4844.
// - Entry five sits at address 0x25 and resets to 0x4a55.
// - Entry seven sits at address 0x27 and resets to 0x4f77 with its return flag set.
package seqstk_pkg;
  // ********************************
  // entry layout
  // ********************************
  localparam int unsigned entry_width = 16;
  localparam int unsigned entry_count = 8;
  localparam int unsigned dir_bit = 15;
  localparam int unsigned addr_hi = 14;
  localparam int unsigned addr_lo = 9;
  localparam int unsigned return_bit = 8;
  localparam int unsigned chan_b_hi = 7;
  localparam int unsigned chan_b_lo = 4;
  localparam int unsigned chan_a_hi = 3;
  localparam int unsigned chan_a_lo = 0;
  // ********************************
  // register indices (word index, byte address is four times)
  // ********************************
  localparam logic [5:0] entry_base_index = 6'h20;
  localparam logic [5:0] entry_four_index = 6'h24;
  localparam logic [5:0] entry_five_index = 6'h25;
  localparam logic [5:0] entry_seven_index = 6'h27;
  localparam logic [5:0] seq_ctrl_index = 6'h30;
  localparam logic [5:0] seq_status_index = 6'h31;
  localparam logic [5:0] conv_count_index = 6'h32;
  // ********************************
  // reset values, entries zero to seven
  // ********************************
  localparam logic [15:0] entry_reset [8] = '{16'h4000, 16'h4211, 16'h4422, 16'h4633,
                                              16'h4844, 16'h4a55, 16'h4c66, 16'h4f77};
  localparam logic [15:0] conv_cycles_reset = 16'h0014;
  // ********************************
  // ahb-lite codes
  // ********************************
  localparam logic [1:0] htrans_nonseq = 2'h2;
  localparam logic [2:0] hsize_word = 3'h2;
endpackage

// file: rtl/seqstk_conv_timer.sv
// conversion timer: models the converter busy time in mclk cycles
// assumes start pulses come from the sequencer on the same clock
`timescale 1ns/100ps
module seqstk_conv_timer (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // control
  input wire logic start,
  input wire logic [15:0] cycles,
  // status
  output logic busy,
  output logic done
);
  logic [15:0] count;
  logic [15:0] next_count;
  logic next_busy;
  logic next_done;

  always_comb begin
    next_count = count;
    next_busy = busy;
    next_done = 1'b0;
    if (busy) begin
      if (count <= 16'h0001) begin
        next_busy = 1'b0;
        next_done = 1'b1;
        next_count = 16'h0000;
      end else begin
        next_count = count - 16'h0001;
      end
    end else if (start) begin
      next_busy = 1'b1;
      next_count = cycles;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      count <= 16'h0000;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      count <= next_count;
      busy <= next_busy;
      done <= next_done;
    end
  end
endmodule

// file: rtl/seqstk_entry.sv
// one sequencer stack entry register with its own reset value
// assumes writes are decoded by the parent bus slave
`timescale 1ns/100ps
module seqstk_entry #(
  parameter logic [15:0] reset_value = 16'h0000
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // write port
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  // contents
  output logic [15:0] value
);
  logic [15:0] next_value;

  always_comb begin
    next_value = value;
    if (wr_en) begin
      next_value = wr_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      value <= reset_value;
    end else begin
      value <= next_value;
    end
  end
endmodule

// file: rtl/seqstk_top.sv
// sequencer stack entry bank with an ahb-lite slave and channel sequencer
// assumes a single ahb-lite master on mclk; only word transfers are meaningful
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/100ps
module seqstk_top (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // converter side
  output logic [3:0] converter_a_channel_select,
  output logic [3:0] converter_b_channel_select,
  output logic [2:0] active_entry,
  output logic conv_start
);
  // ********************************
  // bus address phase capture
  // ********************************
  logic dp_write;
  logic dp_read;
  logic [5:0] dp_index;
  logic next_dp_write;
  logic next_dp_read;
  logic [5:0] next_dp_index;
  logic take;

  assign take = hsel && hready && (htrans == seqstk_pkg::htrans_nonseq);

  always_comb begin
    next_dp_write = take && hwrite;
    next_dp_read = take && !hwrite;
    next_dp_index = take ? haddr[7:2] : dp_index;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      dp_write <= 1'b0;
      dp_read <= 1'b0;
      dp_index <= 6'h00;
    end else begin
      dp_write <= next_dp_write;
      dp_read <= next_dp_read;
      dp_index <= next_dp_index;
    end
  end

  // ********************************
  // stack entries
  // ********************************
  logic [15:0] entry [seqstk_pkg::entry_count];
  logic [seqstk_pkg::entry_count-1:0] entry_wr;

  for (genvar i = 0; i < seqstk_pkg::entry_count; i++) begin : g_entry
    assign entry_wr[i] = dp_write && (dp_index == seqstk_pkg::entry_base_index + 6'(i));
    seqstk_entry #(
      .reset_value(seqstk_pkg::entry_reset[i])
    ) u_entry (
      .mclk(mclk),
      .reset(reset),
      .wr_en(entry_wr[i]),
      .wr_data(hwdata[15:0]),
      .value(entry[i])
    );
  end

  // ********************************
  // control registers
  // ********************************
  // control: bit 0 run enable; conv_count: conversion time in cycles
  logic run_en;
  logic next_run_en;
  logic [15:0] conv_cycles;
  logic [15:0] next_conv_cycles;

  always_comb begin
    next_run_en = run_en;
    next_conv_cycles = conv_cycles;
    if (dp_write && dp_index == seqstk_pkg::seq_ctrl_index) begin
      next_run_en = hwdata[0];
    end
    if (dp_write && dp_index == seqstk_pkg::conv_count_index) begin
      // zero would hang nothing but gives a one-cycle conversion
      next_conv_cycles = hwdata[15:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      run_en <= 1'b0;
      conv_cycles <= seqstk_pkg::conv_cycles_reset;
    end else begin
      run_en <= next_run_en;
      conv_cycles <= next_conv_cycles;
    end
  end

  // ********************************
  // sequencer
  // ********************************
  typedef enum logic [1:0] {
    seqstk_idle_s = 2'b00,
    seqstk_start_s = 2'b01,
    seqstk_wait_s = 2'b10
  } seqstk_state_t;

  seqstk_state_t state;
  seqstk_state_t next_state;
  logic [2:0] next_active_entry;
  logic next_conv_start;
  logic [3:0] next_chan_a;
  logic [3:0] next_chan_b;
  logic conv_busy;
  logic conv_done;
  logic [15:0] cur_entry;

  assign cur_entry = entry[active_entry];

  seqstk_conv_timer u_timer (
    .mclk(mclk),
    .reset(reset),
    .start(conv_start),
    .cycles(conv_cycles),
    .busy(conv_busy),
    .done(conv_done)
  );

  always_comb begin
    next_state = state;
    next_active_entry = active_entry;
    next_conv_start = 1'b0;
    next_chan_a = converter_a_channel_select;
    next_chan_b = converter_b_channel_select;
    unique case (state)
      seqstk_idle_s: begin
        if (run_en) begin
          next_active_entry = 3'h0;
          next_state = seqstk_start_s;
        end
      end
      seqstk_start_s: begin
        next_chan_b = cur_entry[seqstk_pkg::chan_b_hi:seqstk_pkg::chan_b_lo];
        next_chan_a = cur_entry[seqstk_pkg::chan_a_hi:seqstk_pkg::chan_a_lo];
        next_conv_start = 1'b1;
        next_state = seqstk_wait_s;
      end
      seqstk_wait_s: begin
        if (conv_done) begin
          if (cur_entry[seqstk_pkg::return_bit]) begin
            next_active_entry = 3'h0;
          end else begin
            next_active_entry = active_entry + 3'h1;
          end
          next_state = run_en ? seqstk_start_s : seqstk_idle_s;
        end
      end
      default: begin
        next_state = seqstk_idle_s;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state <= seqstk_idle_s;
      active_entry <= 3'h0;
      conv_start <= 1'b0;
      converter_a_channel_select <= 4'h0;
      converter_b_channel_select <= 4'h0;
    end else begin
      state <= next_state;
      active_entry <= next_active_entry;
      conv_start <= next_conv_start;
      converter_a_channel_select <= next_chan_a;
      converter_b_channel_select <= next_chan_b;
    end
  end

  // ********************************
  // read data
  // ********************************
  logic [31:0] next_hrdata;

  always_comb begin
    next_hrdata = 32'h0000_0000;
    if (take && !hwrite) begin
      if (haddr[7:5] == 3'h4 && haddr[4:2] <= 3'h7 && haddr[7:2] < 6'h28) begin
        // direction and address fields read back as stored
        next_hrdata = {16'h0000, entry[haddr[4:2]]};
      end else if (haddr[7:2] == seqstk_pkg::seq_ctrl_index) begin
        next_hrdata = {31'h0000_0000, run_en};
      end else if (haddr[7:2] == seqstk_pkg::seq_status_index) begin
        next_hrdata = {26'h000_0000, conv_busy, state != seqstk_idle_s, 1'b0, active_entry};
      end else if (haddr[7:2] == seqstk_pkg::conv_count_index) begin
        next_hrdata = {16'h0000, conv_cycles};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_done_nowrap;
    state == seqstk_wait_s && conv_done && !cur_entry[seqstk_pkg::return_bit];
  endsequence
  sequence s_done_wrap;
    state == seqstk_wait_s && conv_done && cur_entry[seqstk_pkg::return_bit];
  endsequence

  property p_step;
    s_done_nowrap |=> active_entry == $past(active_entry) + 3'h1;
  endproperty
  a_step: assert property (p_step) else $error("sequencer did not step");
  property p_wrap;
    s_done_wrap |=> active_entry == 3'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("sequencer did not wrap");
  property p_chan_b;
    conv_start |-> converter_b_channel_select == entry[active_entry][7:4];
  endproperty
  a_chan_b: assert property (p_chan_b) else $error("channel b mismatch");
  property p_chan_a;
    conv_start |-> converter_a_channel_select == entry[active_entry][3:0];
  endproperty
  a_chan_a: assert property (p_chan_a) else $error("channel a mismatch");
  property p_four_rst;
    $fell(reset) |-> entry[4] == 16'h4844;
  endproperty
  a_four_rst: assert property (@(posedge mclk) p_four_rst) else $error("entry four reset");
  property p_five_rst;
    $fell(reset) |-> entry[5] == 16'h4a55;
  endproperty
  a_five_rst: assert property (@(posedge mclk) p_five_rst) else $error("entry five reset");
  property p_seven_rst;
    $fell(reset) |-> entry[7] == 16'h4f77 && entry[7][8];
  endproperty
  a_seven_rst: assert property (@(posedge mclk) p_seven_rst) else $error("entry seven reset");
  property p_write;
    dp_write && dp_index == 6'h24 |=> entry[4] == $past(hwdata[15:0]);
  endproperty
  a_write: assert property (p_write) else $error("entry write lost");
  property p_first;
    state == seqstk_idle_s && run_en |=> active_entry == 3'h0 ##1 conv_start;
  endproperty
  a_first: assert property (p_first) else $error("sequence did not start at first");
  sequence s_entry_read;
    take && !hwrite && haddr[7:5] == 3'h4;
  endsequence
  property p_read_entry;
    s_entry_read |=> hrdata == {16'h0000, $past(entry[haddr[4:2]])};
  endproperty
  a_read_entry: assert property (p_read_entry) else $error("entry read back wrong");
  property p_five_write;
    dp_write && dp_index == seqstk_pkg::entry_five_index |=> entry[5] == $past(hwdata[15:0]);
  endproperty
  a_five_write: assert property (p_five_write) else $error("entry five write lost");
  property p_wait_hold;
    state == seqstk_wait_s && !conv_done |=> active_entry == $past(active_entry);
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("entry moved before conversion end");
  property p_chan_hold;
    !conv_start |-> $stable(converter_a_channel_select) && $stable(converter_b_channel_select);
  endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("channel select moved between starts");
  property p_start_one;
    conv_start |=> !conv_start;
  endproperty
  a_start_one: assert property (p_start_one) else $error("start pulse too long");
  property p_idle_quiet;
    state == seqstk_idle_s |-> !conv_start;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("start while idle");
  property p_next_start;
    state == seqstk_wait_s && conv_done && run_en |=> ##1 conv_start;
  endproperty
  a_next_start: assert property (p_next_start) else $error("next conversion not started");
endmodule

// file: sim/seqstk_host_model.sv
// host controller model: a single ahb-lite master that programs the entry bank
// assumes one mclk domain and a slave whose hreadyout is fed back as hready
`timescale 1ns/100ps
module seqstk_host_model (
  // clock
  input wire logic mclk,
  // ahb-lite master side
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  // slave answer
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = seqstk_pkg::hsize_word;
    hwdata = 32'h00000000;
  end
  // ********************************
  // bus cycles
  // ********************************
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= addr;
    htrans <= seqstk_pkg::htrans_nonseq;
    hwrite <= wr;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~addr;
    hwdata <= wdata;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    rdata = hrdata;
    // released data lines must not keep showing the old value
    hwdata <= ~wdata;
  endtask
  task automatic write_word(input logic [31:0] addr, input logic [31:0] wdata);
    logic [31:0] unused;
    xfer(1'b1, addr, wdata, unused);
  endtask
  task automatic read_word(input logic [31:0] addr, output logic [31:0] rdata);
    xfer(1'b0, addr, 32'h00000000, rdata);
  endtask
  task automatic write_entry(input int idx, input logic dir, input logic ret, input logic [3:0] chan_b,
                             input logic [3:0] chan_a);
    logic [5:0] self_addr;
    self_addr = seqstk_pkg::entry_base_index + 6'(idx);
    write_word(32'h00000080 + 32'(4 * idx), {16'h0000, dir, self_addr, ret, chan_b, chan_a});
  endtask
endmodule

// file: sim/seqstk_bench.sv
// self-checking bench for the sequencer stack entry bank
// assumes the host model drives the bus and the bench watches the converter side
`timescale 1ns/100ps
module seqstk_bench;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic hsel, hwrite, hready, hresp, conv_start;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, active_entry;
  logic [3:0] chan_a, chan_b;
  logic [15:0] exp_ent [8] = '{16'h4000, 16'h4211, 16'h4422, 16'h4633,
                               16'h4844, 16'h4a55, 16'h4c66, 16'h4f77};
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  seqstk_top dut (.mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .converter_a_channel_select(chan_a),
    .converter_b_channel_select(chan_b), .active_entry(active_entry), .conv_start(conv_start));
  seqstk_host_model host (.mclk(mclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));
  always #25 mclk = ~mclk;
  // ********************************
  // checking and closing
  // ********************************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // a hang in any wait ends the run here
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      print_verdict();
    end
  end
  task automatic wait_start();
    int i;
    i = 0;
    @(posedge mclk);
    #1;
    while (conv_start !== 1'b1 && i < 60) begin
      @(posedge mclk);
      #1;
      i++;
    end
    if (conv_start !== 1'b1) check("conv_start", 32'h1, {31'h0, conv_start});
  endtask
  // runs n conversions; entries are expected to repeat with period last + 1
  task automatic run_seq(input int n, input int last);
    int idx;
    int i;
    host.write_word(32'h000000c8, 32'h00000002);
    host.write_word(32'h000000c0, 32'h00000001);
    for (int k = 0; k < n; k++) begin
      wait_start();
      idx = k % (last + 1);
      check("active_entry", 32'(idx), {29'h0, active_entry});
      check("chan_a", {28'h0, exp_ent[idx][3:0]}, {28'h0, chan_a});
      check("chan_b", {28'h0, exp_ent[idx][7:4]}, {28'h0, chan_b});
    end
    host.write_word(32'h000000c0, 32'h00000000);
    i = 0;
    rd = 32'h00000010;
    while (rd[4] !== 1'b0 && i < 20) begin
      host.read_word(32'h000000c4, rd);
      i++;
    end
    check("running", 32'h0, {31'h0, rd[4]});
  endtask
  // ********************************
  // tests
  // ********************************
  initial begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      host.read_word(32'h00000080 + 32'(4 * i), rd);
      check("entry reset", {16'h0000, exp_ent[i]}, rd);
      check("hresp", 32'h0, {31'h0, hresp});
    end
    $display("test reset values done");
    host.write_word(32'h000000fc, 32'h0000ffff);
    host.read_word(32'h000000fc, rd);
    check("unmapped", 32'h00000000, rd);
    $display("test unmapped done");
    run_seq(10, 7);
    $display("test default sequence done");
    exp_ent[0] = 16'hc0a3;
    exp_ent[1] = 16'h42b5;
    exp_ent[2] = 16'hc5c7;
    host.write_entry(0, 1'b1, 1'b0, 4'ha, 4'h3);
    host.write_entry(1, 1'b0, 1'b0, 4'hb, 4'h5);
    host.write_entry(2, 1'b1, 1'b1, 4'hc, 4'h7);
    exp_ent[3] = 16'h4691;
    exp_ent[4] = 16'hc828;
    exp_ent[5] = 16'h4b6d;
    host.write_entry(3, 1'b0, 1'b0, 4'h9, 4'h1);
    host.write_entry(4, 1'b1, 1'b0, 4'h2, 4'h8);
    host.write_entry(5, 1'b0, 1'b1, 4'h6, 4'hd);
    for (int i = 0; i < 6; i++) begin
      host.read_word(32'h00000080 + 32'(4 * i), rd);
      check("entry readback", {16'h0000, exp_ent[i]}, rd);
    end
    run_seq(5, 2);
    $display("test early return done");
    print_verdict();
  end
endmodule
